// ---- logic/periodic_timer_defs.vh ----
// Register map, field positions and reset values of the periodic timer
`ifndef PERIODIC_TIMER_DEFS_VH
`define PERIODIC_TIMER_DEFS_VH

`define PT_OFS_CTRL0      8'h00
`define PT_OFS_CTRL1      8'h04
`define PT_OFS_CNT_LO     8'h08
`define PT_OFS_CNT_HI     8'h0C
`define PT_OFS_CMPA_LO    8'h10
`define PT_OFS_CMPA_HI    8'h14
`define PT_OFS_CMPP_LO    8'h18
`define PT_OFS_CMPP_HI    8'h1C
`define PT_OFS_FLAGS      8'h20

`define PT_C0_PAUSE       7
`define PT_C0_CLK_HI      6
`define PT_C0_CLK_LO      4
`define PT_C0_RUN         3
`define PT_C1_MODE_HI     7
`define PT_C1_MODE_LO     6
`define PT_C1_FUNC_HI     5
`define PT_C1_FUNC_LO     4
`define PT_C1_INIT        3
`define PT_C1_INV         2
`define PT_C1_CAPSRC      1
`define PT_C1_CLRSEL      0

`define PT_C0_MASK        8'hF8
`define PT_C0_RESET       8'h00
`define PT_C1_RESET       8'h00
`define PT_CNT_RESET      10'h000

`define PT_MODE_CMP       2'b00
`define PT_MODE_CAP       2'b01
`define PT_MODE_PWM       2'b10
`define PT_MODE_TMR       2'b11

`define PT_CK_SYS4        3'b000
`define PT_CK_SYS         3'b001
`define PT_CK_H16         3'b010
`define PT_CK_H64         3'b011
`define PT_CK_TB0         3'b100
`define PT_CK_TB1         3'b101
`define PT_CK_EXTR        3'b110
`define PT_CK_EXTF        3'b111

`define PT_DIV_SYS        4
`define PT_DIV_H16        16
`define PT_DIV_H64        64

`endif

// ---- logic/pin_sync.v ----
// Two flip-flop synchroniser with edge outputs taken after the second stage
`timescale 1ns/100ps
module pin_sync (
	// Clock and reset
	input  wire hclk,
	input  wire hresetn,
	input  wire clk_en,
	// Pin and result
	input  wire pin,
	output reg  level,
	output wire rise,
	output wire fall
);
	reg meta_q;
	reg prev_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= 1'b0;
			level  <= 1'b0;
			prev_q <= 1'b0;
		end else if (clk_en) begin
			meta_q <= pin;
			level  <= meta_q;
			prev_q <= level;
		end
	end

	assign rise = clk_en & level & ~prev_q;
	assign fall = clk_en & ~level & prev_q;
endmodule

// ---- logic/periodic_timer.v ----
// Periodic timer: AHB-Lite registers, 10-bit counter, compare, capture, output
//
// Function
// - Pause bit high halts counting; clearing it resumes counting.
// - Pause keeps the counter value; counting resumes from it.
// - Clock field selects sys/4, sys, high/16, high/64, timebase, pin edges.
// - Rising edge of run bit zeroes the counter; run high enables counting.
// - Run falling stops counting and keeps the counter value.
// - Run rising edge resets output to initial level, compare/waveform modes.
// - Mode field: compare, capture, waveform/single pulse, plain timer.
// - Compare mode A match: output unchanged, low, high or toggled.
// - Waveform mode function: inactive, active, periodic waveform, single pulse.
// - Capture mode function: rising, falling, both edges, disabled.
// - Initial-level bit: start level in compare, active level in waveform.
// - Requested level equal to initial level gives no visible change.
// - Invert bit inverts the output pin, except in plain timer and capture modes.
// - Capture source is capture pin when 0, external clock pin when 1.
// - Clear-select 1 clears on A match; 0 on P match or overflow.
// - Overflow clears only when compare P is zero and, in compare and timer modes, clear-select is 0.
// - Clear-select is ignored in waveform, single pulse and capture modes.
// - Counter readable as low byte and two high bits; upper bits zero.
// - Compare A and P are read/write 10-bit values split low/high.
// - Plain timer mode leaves output undriven; initial level unused.
// - 10-bit up counter compared continuously with A and P.
// - Compare mode, clear-select low: both A and P flags raised.
// - Compare mode, clear-select high: only the A flag raised.
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "periodic_timer_defs.vh"
module periodic_timer #(
	parameter CNT_W = 10
) (
	// Clock, reset, enable
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        clk_en,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output reg  [31:0] hrdata,
	output wire        hresp,
	// Clock ticks from elsewhere on hclk
	input  wire        high_speed_tick,
	input  wire        timebase_tick,
	// Pins
	input  wire        external_clock_pin,
	input  wire        capture_input_pin,
	output reg         timer_output_pin,
	output wire        timer_output_oe,
	// Events
	output reg         compare_a_flag,
	output reg         compare_p_flag,
	output reg         capture_event
);
	reg  [7:0]       ctrl0_q;
	reg  [7:0]       ctrl1_q;
	reg  [CNT_W-1:0] cnt_q;
	reg  [CNT_W-1:0] cmpa_q;
	reg  [CNT_W-1:0] cmpp_q;
	reg  [CNT_W-1:0] cap_q;
	reg  [1:0]       flags_q;
	reg              run_prev_q;
	reg              wave_q;
	reg              pulse_done_q;
	reg  [1:0]       sys_div_q;
	reg  [5:0]       h_div_q;
	reg              wr_q;
	reg  [7:0]       wa_q;

	wire       pause   = ctrl0_q[`PT_C0_PAUSE];
	wire [2:0] ck_sel  = ctrl0_q[`PT_C0_CLK_HI:`PT_C0_CLK_LO];
	wire       run     = ctrl0_q[`PT_C0_RUN];
	wire [1:0] mode    = ctrl1_q[`PT_C1_MODE_HI:`PT_C1_MODE_LO];
	wire [1:0] func    = ctrl1_q[`PT_C1_FUNC_HI:`PT_C1_FUNC_LO];
	wire       init    = ctrl1_q[`PT_C1_INIT];
	wire       inv     = ctrl1_q[`PT_C1_INV];
	wire       capsrc  = ctrl1_q[`PT_C1_CAPSRC];
	wire       clrsel  = ctrl1_q[`PT_C1_CLRSEL];

	// Pin synchronisers
	wire ext_lvl, ext_rise, ext_fall;
	wire cap_lvl, cap_rise, cap_fall;
	pin_sync u_ext (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_en  (clk_en),
		.pin     (external_clock_pin),
		.level   (ext_lvl),
		.rise    (ext_rise),
		.fall    (ext_fall)
	);
	pin_sync u_cap (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_en  (clk_en),
		.pin     (capture_input_pin),
		.level   (cap_lvl),
		.rise    (cap_rise),
		.fall    (cap_fall)
	);

	// AHB-Lite: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	wire   ahb_go    = hsel & hready & htrans[1];
	wire   run_rise  = run & ~run_prev_q;

	// Write data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
		end else if (clk_en) begin
			wr_q <= ahb_go & hwrite;
			wa_q <= haddr[7:0];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl0_q <= `PT_C0_RESET;
			ctrl1_q <= `PT_C1_RESET;
			cmpa_q  <= `PT_CNT_RESET;
			cmpp_q  <= `PT_CNT_RESET;
		end else if (clk_en && wr_q) begin
			case (wa_q)
			`PT_OFS_CTRL0: ctrl0_q <= hwdata[7:0] & `PT_C0_MASK;
			`PT_OFS_CTRL1: ctrl1_q <= hwdata[7:0];
			`PT_OFS_CMPA_LO: cmpa_q[7:0] <= hwdata[7:0];
			`PT_OFS_CMPA_HI: cmpa_q[9:8] <= hwdata[1:0];
			`PT_OFS_CMPP_LO: cmpp_q[7:0] <= hwdata[7:0];
			`PT_OFS_CMPP_HI: cmpp_q[9:8] <= hwdata[1:0];
			default: ;
			endcase
		end
	end

	// Read data registered at the address phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en && ahb_go && !hwrite) begin
			case (haddr[7:0])
			`PT_OFS_CTRL0:   hrdata <= {24'h00_0000, ctrl0_q};
			`PT_OFS_CTRL1:   hrdata <= {24'h00_0000, ctrl1_q};
			`PT_OFS_CNT_LO:  hrdata <= {24'h00_0000, cnt_q[7:0]};
			`PT_OFS_CNT_HI:  hrdata <= {30'h0000_0000, cnt_q[9:8]};
			`PT_OFS_CMPA_LO: hrdata <= {24'h00_0000, cmpa_q[7:0]};
			`PT_OFS_CMPA_HI: hrdata <= {30'h0000_0000, cmpa_q[9:8]};
			`PT_OFS_CMPP_LO: hrdata <= {24'h00_0000, cmpp_q[7:0]};
			`PT_OFS_CMPP_HI: hrdata <= {30'h0000_0000, cmpp_q[9:8]};
			`PT_OFS_FLAGS:
				hrdata <= {6'h00, cap_q, 14'h0000, flags_q};
			default:         hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Internal clock dividers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sys_div_q <= 2'b00;
			h_div_q   <= 6'h00;
		end else if (clk_en) begin
			sys_div_q <= sys_div_q + 2'b01;
			if (high_speed_tick)
				h_div_q <= h_div_q + 6'h01;
		end
	end

	reg tick;
	always @* begin
		case (ck_sel)
		`PT_CK_SYS4: tick = (sys_div_q == 2'b11);
		`PT_CK_SYS:  tick = 1'b1;
		`PT_CK_H16:  tick = high_speed_tick & (h_div_q[3:0] == 4'hF);
		`PT_CK_H64:  tick = high_speed_tick & (h_div_q == 6'h3F);
		`PT_CK_TB0:  tick = timebase_tick;
		`PT_CK_TB1:  tick = timebase_tick;
		`PT_CK_EXTR: tick = ext_rise;
		`PT_CK_EXTF: tick = ext_fall;
		default:     tick = 1'b0;
		endcase
	end

	// Comparators and clearing
	wire counting = run & ~pause & tick;
	wire match_a  = counting & (cnt_q == cmpa_q) &
		(cmpa_q != 10'h000);
	wire match_p  = counting & (cnt_q == cmpp_q);
	wire ovf      = counting & (&cnt_q);
	wire cmp_like = (mode == `PT_MODE_CMP) | (mode == `PT_MODE_TMR);
	wire pwm_mode = (mode == `PT_MODE_PWM);
	reg  clear_cnt;
	always @* begin
		if (cmp_like)
			clear_cnt = clrsel ? match_a :
				(cmpp_q == 10'h000 ? ovf : match_p);
		else
			// A zero period runs the full range instead of clearing each tick
			clear_cnt = (cmpp_q == 10'h000) ? ovf : match_p;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q      <= `PT_CNT_RESET;
			run_prev_q <= 1'b0;
		end else if (clk_en) begin
			run_prev_q <= run;
			if (run_rise)
				cnt_q <= `PT_CNT_RESET;
			else if (clear_cnt || (pwm_mode && pulse_done_q))
				cnt_q <= `PT_CNT_RESET;
			else if (counting)
				cnt_q <= cnt_q + 10'h001;
		end
	end

	// Match events; sticky flags cleared by write-one, set wins
	wire ev_a = match_a & (mode != `PT_MODE_CAP);
	wire ev_p = match_p & (mode != `PT_MODE_CAP) &
		~(cmp_like & clrsel);
	wire fclr = wr_q & (wa_q == `PT_OFS_FLAGS);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_a_flag <= 1'b0;
			compare_p_flag <= 1'b0;
			flags_q        <= 2'b00;
		end else if (clk_en) begin
			compare_a_flag <= ev_a;
			compare_p_flag <= ev_p;
			flags_q[0] <= ev_a | (flags_q[0] & ~(fclr & hwdata[0]));
			flags_q[1] <= ev_p | (flags_q[1] & ~(fclr & hwdata[1]));
		end
	end

	// Capture
	wire c_rise = capsrc ? ext_rise : cap_rise;
	wire c_fall = capsrc ? ext_fall : cap_fall;
	reg  cap_hit;
	always @* begin
		case (func)
		2'b00:   cap_hit = c_rise;
		2'b01:   cap_hit = c_fall;
		2'b10:   cap_hit = c_rise | c_fall;
		default: cap_hit = 1'b0;
		endcase
	end
	wire cap_ev = (mode == `PT_MODE_CAP) & run & cap_hit;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_q         <= `PT_CNT_RESET;
			capture_event <= 1'b0;
		end else if (clk_en) begin
			capture_event <= cap_ev;
			if (cap_ev)
				cap_q <= cnt_q;
		end
	end

	// Output waveform, before polarity
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wave_q       <= 1'b0;
			pulse_done_q <= 1'b0;
		end else if (clk_en) begin
			if (run_rise) begin
				wave_q       <= init;
				pulse_done_q <= 1'b0;
			end else if (mode == `PT_MODE_CMP && ev_a) begin
				case (func)
				2'b01:   wave_q <= 1'b0;
				2'b10:   wave_q <= 1'b1;
				2'b11:   wave_q <= ~wave_q;
				default: wave_q <= wave_q;
				endcase
			end else if (pwm_mode) begin
				case (func)
				2'b00: wave_q <= ~init;
				2'b01: wave_q <= init;
				2'b10: begin
					if (clear_cnt)
						wave_q <= init;
					else if (match_a)
						wave_q <= ~init;
				end
				default: begin
					if (match_a && !pulse_done_q) begin
						wave_q       <= ~init;
						pulse_done_q <= 1'b1;
					end else if (!pulse_done_q && run) begin
						wave_q <= init;
					end
				end
				endcase
			end
		end
	end

	// Single pulse idles once done; pin held low while not driving
	wire out_used = (mode == `PT_MODE_CMP) | pwm_mode;
	assign timer_output_oe = out_used;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			timer_output_pin <= 1'b0;
		else if (clk_en)
			timer_output_pin <= out_used ? (wave_q ^ inv) : 1'b0;
	end
endmodule

// ---- testbench/periodic_timer_assertions.sv ----
// Port-level assertions for the periodic timer
`timescale 1ns/100ps
module periodic_timer_assertions (
	// Clock and reset
	input wire        hclk,
	input wire        hresetn,
	input wire        clk_en,
	// Bus
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	// Timer outputs
	input wire        timer_output_pin,
	input wire        timer_output_oe,
	input wire        compare_a_flag,
	input wire        compare_p_flag,
	input wire        capture_event
);
	reg  [7:0] c0_q;
	reg  [7:0] c1_q;
	reg  [7:0] wa_q;
	reg        wr_q;
	wire       take = hsel & hready & htrans[1] & hwrite & clk_en;
	// Shadow of the control registers, loaded at the edge a write lands
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			c0_q <= 8'h00;
			c1_q <= 8'h00;
		end else begin
			wr_q <= take;
			wa_q <= haddr[7:0];
			if (wr_q && wa_q == 8'h00)
				c0_q <= hwdata[7:0] & 8'hF8;
			if (wr_q && wa_q == 8'h04)
				c1_q <= hwdata[7:0];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_pin_idle: assert property (!timer_output_oe |-> !timer_output_pin)
		else $error("pin high while undriven");
	a_oe_mode: assert property (timer_output_oe == !c1_q[6])
		else $error("output enable does not follow mode");
	a_a_pulse: assert property (compare_a_flag |=> !compare_a_flag)
		else $error("compare A flag longer than a pulse");
	a_p_pulse: assert property (compare_p_flag |=> !compare_p_flag)
		else $error("compare P flag longer than a pulse");
	a_p_clrsel: assert property ($past(c1_q[7:6]) == 2'b00 &&
		$past(c1_q[0]) |-> !compare_p_flag)
		else $error("compare P flag with clear on A");
	a_cap_gate: assert property (capture_event |->
		$past(c1_q[7:6]) == 2'b01 && $past(c1_q[5:4]) != 2'b11)
		else $error("capture outside enabled capture mode");
	a_run_init: assert property ($rose(c0_q[3]) &&
		c1_q[7:6] == 2'b00
		|-> ##2 timer_output_pin == (c1_q[3] ^ c1_q[2]))
		else $error("pin not at initial level after run");
endmodule
bind periodic_timer periodic_timer_assertions i_periodic_timer_assertions (
	.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hreadyout, .hresp, .timer_output_pin, .timer_output_oe,
	.compare_a_flag, .compare_p_flag, .capture_event);

// ---- testbench/periodic_timer_tb.sv ----
// Self-checking testbench for the periodic timer
`timescale 1ns/100ps
module periodic_timer_tb;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic        high_speed_tick, timebase_tick, free;
	logic        external_clock_pin, capture_input_pin, timer_output_pin;
	logic        timer_output_oe, compare_a_flag, compare_p_flag;
	logic        capture_event, e;
	logic [3:0]  m;
	int          mismatches, checks_done, cyc, caps, n, i, x;
	// Clock code, lowest and highest count after the fixed span
	logic [18:0] ck [8] = '{{3'h0, 8'h30, 8'h34}, {3'h1, 8'hC6, 8'hCD},
		{3'h2, 8'h05, 8'h07}, {3'h3, 8'h01, 8'h02}, {3'h4, 8'h18, 8'h1A},
		{3'h5, 8'h18, 8'h1A}, {3'h6, 8'h0B, 8'h0E}, {3'h7, 8'h0B, 8'h0E}};
	logic [7:0]  ofs [9] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C,
		8'h08, 8'h0C, 8'h40};
	logic [7:0]  exv [9] = '{8'hF8, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'h03,
		8'h00, 8'h00, 8'h00};
	periodic_timer i_periodic_timer (.hclk, .hresetn, .clk_en(1'b1), .hsel,
		.haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .high_speed_tick,
		.timebase_tick, .external_clock_pin, .capture_input_pin,
		.timer_output_pin, .timer_output_oe, .compare_a_flag,
		.compare_p_flag, .capture_event);
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Tick sources and a free pin clock; the ceiling cuts a hang short
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		high_speed_tick <= cyc[0];
		timebase_tick <= (cyc[2:0] == 3'h0);
		if (free)
			external_clock_pin <= cyc[3];
		if (capture_event === 1'b1)
			caps <= caps + 1;
		if (cyc == 20000) begin
			mismatches++;
			report_and_stop;
		end
	end
	task tick(input int k);
		repeat (k) @(posedge hclk);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		haddr <= {24'h00_0000, a};
		hwrite <= 1'b1;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] r);
		haddr <= {24'h00_0000, a};
		hwrite <= 1'b0;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task rng(input logic [31:0] g, input logic [31:0] lo, hi);
		checks_done++;
		if (((g >= lo) && (g <= hi)) !== 1'b1) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h..%h", $time, g, lo, hi);
		end
	endtask
	task pulse(input logic s);
		if (s)
			external_clock_pin <= 1'b1;
		else
			capture_input_pin <= 1'b1;
		tick(6);
		external_clock_pin <= 1'b0;
		capture_input_pin <= 1'b0;
		tick(6);
	endtask
	initial begin
		{hresetn, hsel, hwrite, htrans, free} = '0;
		{haddr, hwdata, cyc, caps, mismatches, checks_done} = '0;
		{high_speed_tick, timebase_tick} = 2'b00;
		{external_clock_pin, capture_input_pin} = 2'b00;
		tick(2);
		hresetn <= 1'b1;
		hsel <= 1'b1;
		free <= 1'b1;
		for (i = 0; i < 8; i++) begin
			wr(8'h00, 8'h00);
			wr(8'h00, {1'b0, ck[i][18:16], 4'h8});
			tick(200);
			rd(8'h08, q);
			rng(q, ck[i][15:8], ck[i][7:0]);
		end
		free <= 1'b0;
		$display("clock rows done");
		// Second reset in mid-run, then reset values and access kinds
		hresetn <= 1'b0;
		tick(2);
		hresetn <= 1'b1;
		for (i = 0; i < 9; i++) begin
			rd(8'(i * 4), q);
			chk(q, 32'h0);
		end
		for (i = 0; i < 9; i++)
			wr(ofs[i], 8'hFF);
		for (i = 0; i < 9; i++) begin
			rd(ofs[i], q);
			chk(q, {24'h00_0000, exv[i]});
		end
		$display("register test done");
		wr(8'h00, 8'h00);
		wr(8'h00, 8'h18);
		tick(40);
		wr(8'h00, 8'h98);
		rd(8'h08, q);
		n = q;
		tick(50);
		rd(8'h08, q);
		chk(q, 32'(n));
		wr(8'h00, 8'h18);
		tick(20);
		rd(8'h08, q);
		rng(q, 32'(n + 20), 32'(n + 26));
		wr(8'h00, 8'h10);
		rd(8'h08, q);
		n = q;
		tick(30);
		rd(8'h08, q);
		chk(q, 32'(n));
		wr(8'h00, 8'h18);
		tick(2);
		rd(8'h08, q);
		rng(q, 32'h0, 32'h3);
		$display("pause and run test done");
		wr(8'h00, 8'h00);
		wr(8'h04, 8'h00);
		for (i = 0; i < 4; i++)
			wr(8'(8'h10 + i * 4), i == 0 ? 8'h14 : 8'h00);
		wr(8'h20, 8'h03);
		for (i = 0; i < 16; i++) begin
			m = i;
			wr(8'h00, 8'h00);
			wr(8'h04, {2'b00, m[3:2], m[1], m[0], 2'b01});
			wr(8'h00, 8'h18);
			tick(3);
			chk(32'(timer_output_pin), 32'(m[1] ^ m[0]));
			tick(25);
			e = m[3] ? (m[2] ? ~m[1] : 1'b1) : (m[2] ? 1'b0 : m[1]);
			chk(32'(timer_output_pin), 32'(e ^ m[0]));
		end
		rd(8'h20, q);
		chk(q & 32'h3, 32'h1);
		wr(8'h00, 8'h00);
		wr(8'h18, 8'h1E);
		wr(8'h04, 8'h00);
		wr(8'h20, 8'h03);
		wr(8'h00, 8'h18);
		tick(40);
		rd(8'h20, q);
		chk(q & 32'h3, 32'h3);
		rd(8'h08, q);
		rng(q, 32'h8, 32'h10);
		wr(8'h00, 8'h00);
		wr(8'h04, 8'hA8);
		wr(8'h00, 8'h18);
		tick(10);
		chk(32'(timer_output_pin), 32'h1);
		tick(18);
		chk(32'(timer_output_pin), 32'h0);
		$display("compare test done");
		for (i = 0; i < 8; i++) begin
			m = i;
			wr(8'h00, 8'h00);
			wr(8'h04, {2'b01, m[2:1], 2'b00, m[0], 1'b0});
			wr(8'h00, 8'h18);
			n = caps;
			pulse(~m[0]);
			pulse(m[0]);
			x = m[2:1] == 2'b10 ? 2 : (m[2:1] == 2'b11 ? 0 : 1);
			chk(32'(caps - n), 32'(x));
		end
		chk(32'(timer_output_oe), 32'h0);
		$display("capture test done");
		report_and_stop;
	end
endmodule
